// file: common/psch_pkg.sv
package psch_pkg;
  // -----------------------------------------------------------------
  // sub-command codes
  // -----------------------------------------------------------------
  localparam logic [7:0] CMD_PULLUP_P0    = 8'h1E;  // 30, retired
  localparam logic [7:0] CMD_PULLUP_P1    = 8'h1F;  // 31, retired
  localparam logic [7:0] CMD_SINK_P0      = 8'h20;  // 32, retired
  localparam logic [7:0] CMD_SINK_P1      = 8'h21;  // 33, retired
  localparam logic [7:0] CMD_PWM_LOAD     = 8'h22;  // 34
  localparam logic [7:0] CMD_RDBUF_SETUP  = 8'h23;  // 35
  localparam logic [7:0] CMD_SCRATCH_WR   = 8'h25;  // 37
  localparam logic [7:0] CMD_EVENT_SETUP  = 8'h26;  // 38
  localparam logic [7:0] CMD_OPTION_LOAD  = 8'h28;  // 40

  // -----------------------------------------------------------------
  // limits and reset values
  // -----------------------------------------------------------------
  localparam logic [7:0] PWM_PIN_MAX      = 8'h03;  // pins 0..3
  localparam logic [7:0] PWM_DUTY_MAX     = 8'h64;  // 100 percent
  localparam logic [7:0] SCRATCH_PTR_MAX  = 8'h07;  // entries 0..7
  localparam int         SCRATCH_DEPTH    = 8;
  localparam int         RDBUF_DEPTH      = 7;
  localparam logic [7:0] STROBE_MASK_RST  = 8'h00;
  localparam logic [7:0] COUNT_MASK_RST   = 8'h00;
  localparam logic [7:0] OPTION_RST       = 8'h00;
  localparam logic [7:0] SCRATCH_RST      = 8'h00;

  // -----------------------------------------------------------------
  // option control fields
  // -----------------------------------------------------------------
  localparam int OPT_STATUS_LED_BIT = 0;
  localparam int OPT_SERIAL_EN_BIT  = 1;
  localparam int OPT_ACK_EN_BIT     = 3;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_HZ      = 200_000_000;
  localparam int SERIAL_BAUD = 2400;
  localparam int BAUD_DIV    = CLK_HZ / SERIAL_BAUD;  // rounds down
  localparam int PWM_TICK_HZ = 100_000;               // duty step rate
  localparam int PWM_DIV     = CLK_HZ / PWM_TICK_HZ;

  // command from the packet decoder
  typedef struct packed {
    logic       valid;
    logic [7:0] sub_command_code;
    logic [7:0] low_param_byte;
    logic [7:0] high_param_byte;
  } psch_cmd_type;
endpackage : psch_pkg

// file: rtl/psch_edge_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser with one selectable active edge shared by all bits
module psch_edge_sync #(
  parameter int W = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_pins,
  input  wire logic         i_falling,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_edge
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;     // first stage, read only by s2
    logic [W-1:0] s2;     // stable level
    logic [W-1:0] s3;     // previous stable level
  } psch_sync_type;
  psch_sync_type st_ff;
  psch_sync_type nxt_st;

  // shift chain
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = i_pins;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
  end

  // stages preset on reset to the idle level of the chosen edge sense,
  // so a pin resting at that level gives no false edge after reset
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_ff <= {3{{W{i_falling}}}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_level = st_ff.s2;
  // edge polarity follows the legacy pull-up choice
  assign o_edge  = i_falling ? (st_ff.s3 & ~st_ff.s2) : (~st_ff.s3 & st_ff.s2);
endmodule : psch_edge_sync

// file: rtl/psch_port_setup.sv
`timescale 1ns/100ps
module psch_port_setup (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire psch_pkg::psch_cmd_type i_cmd,
  input  wire logic                 i_legacy_pullup,
  input  wire logic                 i_usb_activity,
  input  wire logic                 i_wr_strobe_req,
  input  wire logic [7:0]           i_port0_pins,
  input  wire logic [3:0]           i_port1_pins,
  input  wire logic                 i_rdbuf_pop,
  input  wire logic [2:0]           i_scratch_rd_addr,
  output logic      [3:0]           o_port1_out,
  output logic      [3:0]           o_port1_oe_n,
  output logic      [7:0]           o_option_control,
  output logic                      o_serial_enable,
  output logic                      o_baud_tick,
  output logic                      o_wr_strobe,
  output logic      [7:0]           o_rdbuf_data,
  output logic      [2:0]           o_rdbuf_count,
  output logic      [7:0]           o_scratch_data,
  output logic      [15:0]          o_event_count
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  // divider widths follow the clock and rate constants, so a faster
  // core clock only widens the counters
  localparam int BW = $clog2(psch_pkg::BAUD_DIV);
  localparam int PW = $clog2(psch_pkg::PWM_DIV);

  typedef struct packed {
    logic [7:0]    strobe_mask;  // port 1 pins acting as read strobe
    logic [7:0]    count_mask;   // port 0 pins counting events
    logic [7:0]    option;       // option control register
    logic [15:0]   events;       // accumulated event count
    logic [2:0]    rd_ptr;       // read buffer head
    logic [2:0]    wr_ptr;       // read buffer tail
    logic [2:0]    count;        // bytes held
    logic [BW-1:0] baud_cnt;     // serial rate divider
    logic [PW-1:0] pwm_cnt;      // pwm step divider
    logic          baud_tick;
    logic          pwm_tick;
    logic          strobe;       // write strobe output level
    logic [7:0]    rd_data;
    logic [7:0]    sp_data;
    logic          led_n;        // status pin level, low on traffic
  } psch_state_type;
  psch_state_type st_ff;
  psch_state_type nxt_st;

  // arrays, not struct fields, so each entry is addressed directly
  logic [7:0] scratch_mem [psch_pkg::SCRATCH_DEPTH];  // user scratch pad
  logic [7:0] rdbuf_mem   [psch_pkg::RDBUF_DEPTH];    // latched port 0 bytes

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  // wrap a buffer pointer at the buffer depth
  function automatic logic [2:0] psch_wrap(input logic [2:0] p);
    psch_wrap = (p == 3'(psch_pkg::RDBUF_DEPTH - 1)) ? 3'h0 : p + 3'h1;
  endfunction : psch_wrap

  // count of set bits, for several coincident events
  function automatic logic [15:0] psch_ones(input logic [7:0] v);
    psch_ones = '0;
    for (int i = 0; i < 8; i++) begin
      psch_ones = psch_ones + {15'h0000, v[i]};
    end
  endfunction : psch_ones

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [7:0] p0_level;
  logic [7:0] p0_edge;
  logic [3:0] p1_level;
  logic [3:0] p1_edge;

  // one pull-up choice covers the whole device, so both ports share
  // the same edge sense
  // port 0 edges for event counting
  psch_edge_sync #(.W(8)) u_p0_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_pins     (i_port0_pins),
    .i_falling  (i_legacy_pullup),
    .o_level    (p0_level),
    .o_edge     (p0_edge)
  );

  // port 1 edges for read strobes
  psch_edge_sync #(.W(4)) u_p1_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_pins     (i_port1_pins),
    .i_falling  (i_legacy_pullup),
    .o_level    (p1_level),
    .o_edge     (p1_edge)
  );

  // -----------------------------------------------------------------
  // command decode
  // -----------------------------------------------------------------
  logic       cmd_pwm_ok;
  logic       cmd_sp_ok;
  logic [3:0] pwm_load;
  logic [3:0] pwm_active;
  logic [3:0] pwm_out;

  // unknown codes match nothing here and fall through like retired ones
  // out-of-range arguments are dropped whole
  assign cmd_pwm_ok = i_cmd.valid && (i_cmd.sub_command_code == psch_pkg::CMD_PWM_LOAD)
                   && (i_cmd.low_param_byte <= psch_pkg::PWM_PIN_MAX)
                   && (i_cmd.high_param_byte <= psch_pkg::PWM_DUTY_MAX);
  assign cmd_sp_ok  = i_cmd.valid && (i_cmd.sub_command_code == psch_pkg::CMD_SCRATCH_WR)
                   && (i_cmd.high_param_byte <= psch_pkg::SCRATCH_PTR_MAX);

  // one-hot load, pin index from low byte, duty from high
  always_comb begin
    pwm_load = 4'h0;
    if (cmd_pwm_ok) begin
      pwm_load[i_cmd.low_param_byte[1:0]] = 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // pwm channels on port 1 pins 0..3
  // -----------------------------------------------------------------
  for (genvar g = 0; g < 4; g++) begin : g_pwm
    psch_pwm_chan u_chan (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_tick     (st_ff.pwm_tick),
      .i_load     (pwm_load[g]),
      .i_duty     (i_cmd.high_param_byte),
      .o_active   (pwm_active[g]),
      .o_pwm      (pwm_out[g])
    );
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  logic       push;
  logic       pop;
  logic [7:0] strobe_hits;

  always_comb begin
    nxt_st      = st_ff;
    strobe_hits = st_ff.strobe_mask & {4'h0, p1_edge};
    pop         = i_rdbuf_pop && (st_ff.count != 3'h0);
    // a full buffer drops new strobes
    // a strobe in the same cycle as a pop still fits
    push        = (strobe_hits != 8'h00)
               && (st_ff.count < 3'(psch_pkg::RDBUF_DEPTH) || pop);

    // command execution
    if (i_cmd.valid) begin
      if (i_cmd.sub_command_code == psch_pkg::CMD_RDBUF_SETUP) begin
        nxt_st.strobe_mask = i_cmd.low_param_byte;
      end else if (i_cmd.sub_command_code == psch_pkg::CMD_OPTION_LOAD) begin
        nxt_st.option = i_cmd.low_param_byte;
      end else if (i_cmd.sub_command_code == psch_pkg::CMD_EVENT_SETUP) begin
        // enable first, disable wins where both set
        nxt_st.count_mask = (st_ff.count_mask | i_cmd.low_param_byte)
                          & ~i_cmd.high_param_byte;
      end
      // codes 30..33 fall through with no effect
    end

    // event counting on enabled pins
    // 16-bit total wraps; the host must read it often enough to see it
    nxt_st.events = st_ff.events + psch_ones(p0_edge & st_ff.count_mask);

    // read buffer pointers
    if (push) begin
      nxt_st.wr_ptr = psch_wrap(st_ff.wr_ptr);
    end
    if (pop) begin
      nxt_st.rd_ptr = psch_wrap(st_ff.rd_ptr);
    end
    if (push && !pop) begin
      nxt_st.count = st_ff.count + 3'h1;
    end else if (pop && !push) begin
      nxt_st.count = st_ff.count - 3'h1;
    end
    nxt_st.rd_data = rdbuf_mem[st_ff.rd_ptr];
    nxt_st.sp_data = scratch_mem[i_scratch_rd_addr];

    // baud divider runs only while the serial port is on
    // restarting from zero on enable puts the first tick one full bit
    // period after the port is switched on
    nxt_st.baud_tick = 1'b0;
    if (!st_ff.option[psch_pkg::OPT_SERIAL_EN_BIT]) begin
      nxt_st.baud_cnt = '0;
    end else if (st_ff.baud_cnt == BW'(psch_pkg::BAUD_DIV - 1)) begin
      nxt_st.baud_cnt  = '0;
      nxt_st.baud_tick = 1'b1;
    end else begin
      nxt_st.baud_cnt = st_ff.baud_cnt + BW'(1);
    end

    // pwm step divider
    // one divider feeds all four channels so their periods stay aligned
    nxt_st.pwm_tick = 1'b0;
    if (st_ff.pwm_cnt == PW'(psch_pkg::PWM_DIV - 1)) begin
      nxt_st.pwm_cnt  = '0;
      nxt_st.pwm_tick = 1'b1;
    end else begin
      nxt_st.pwm_cnt = st_ff.pwm_cnt + PW'(1);
    end

    // strobe stretched while acknowledge held low
    // the request alone starts the strobe; acknowledge only stretches it,
    // so a stuck-low acknowledge pin cannot raise the strobe by itself
    nxt_st.strobe = i_wr_strobe_req
                 || (st_ff.strobe && st_ff.option[psch_pkg::OPT_ACK_EN_BIT]
                     && !p1_level[2]);

    // status pin level registered so the pin sees no input glitches
    nxt_st.led_n = ~i_usb_activity;
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      // named fields listed so their reset values stay visible
      st_ff             <= '0;
      st_ff.strobe_mask <= psch_pkg::STROBE_MASK_RST;
      st_ff.count_mask  <= psch_pkg::COUNT_MASK_RST;
      st_ff.option      <= psch_pkg::OPTION_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // memories, scratch cleared on boot
  // the read buffer needs no reset: count and pointers say what is valid
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int i = 0; i < psch_pkg::SCRATCH_DEPTH; i++) begin
        scratch_mem[i] <= psch_pkg::SCRATCH_RST;
      end
    end else if (cmd_sp_ok) begin
      scratch_mem[i_cmd.high_param_byte[2:0]] <= i_cmd.low_param_byte;
    end
    if (push) begin
      rdbuf_mem[st_ff.wr_ptr] <= p0_level;
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  // pin 3 status led overrides pwm; oe low means driven
  // acknowledge overrides a pwm load on pin 2, so the pin is never
  // driven against the external party
  always_comb begin
    o_port1_out  = pwm_out;
    o_port1_oe_n = ~pwm_active;
    if (st_ff.option[psch_pkg::OPT_STATUS_LED_BIT]) begin
      o_port1_out[3]  = st_ff.led_n;
      o_port1_oe_n[3] = 1'b0;
    end
    if (st_ff.option[psch_pkg::OPT_ACK_EN_BIT]) begin
      o_port1_oe_n[2] = 1'b1;  // acknowledge is an input
    end
  end

  assign o_option_control = st_ff.option;
  assign o_serial_enable  = st_ff.option[psch_pkg::OPT_SERIAL_EN_BIT];
  assign o_baud_tick      = st_ff.baud_tick;
  assign o_wr_strobe      = st_ff.strobe;
  assign o_rdbuf_data     = st_ff.rd_data;
  assign o_rdbuf_count    = st_ff.count;
  assign o_scratch_data   = st_ff.sp_data;
  assign o_event_count    = st_ff.events;
endmodule : psch_port_setup

// file: rtl/psch_pwm_chan.sv
`timescale 1ns/100ps
// one pwm channel, 100 steps per period
module psch_pwm_chan (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst,
  input  wire logic       i_tick,
  input  wire logic       i_load,
  input  wire logic [7:0] i_duty,
  output logic            o_active,
  output logic            o_pwm
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic       active;   // pin in pwm mode
    logic [7:0] duty;     // 0..100
    logic [7:0] phase;    // 0..99
    logic       out;
  } psch_pwm_type;
  psch_pwm_type st_ff;
  psch_pwm_type nxt_st;

  // phase counter and compare
  always_comb begin
    nxt_st = st_ff;
    if (i_load) begin
      nxt_st.active = 1'b1;
      nxt_st.duty   = i_duty;
    end
    if (i_tick) begin
      nxt_st.phase = (st_ff.phase == psch_pkg::PWM_DUTY_MAX - 8'h01) ? 8'h00
                                                                      : st_ff.phase + 8'h01;
    end
    // registered output keeps glitches off the pin
    nxt_st.out = st_ff.active && (st_ff.phase < st_ff.duty);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_active = st_ff.active;
  assign o_pwm    = st_ff.out;
endmodule : psch_pwm_chan

// file: verif/psch_host_model.sv
`timescale 1ns/100ps
// host side: issues one sub-command per call, none for buffer or scratch codes while serial is on, drives at the falling edge
module psch_host_model (
  input  wire logic             i_core_clk,
  input  wire logic             i_serial_on,
  output psch_pkg::psch_cmd_type o_cmd
);
  initial o_cmd = '0;
  // --------------------------------------------------------------
  // one command: valid stands for exactly one rising edge
  // --------------------------------------------------------------
  task automatic send(input logic [7:0] code, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] l;
    l = lo;
    // buffer and scratch share resources with the serial port
    if (i_serial_on && (code == psch_pkg::CMD_RDBUF_SETUP ||
        code == psch_pkg::CMD_SCRATCH_WR)) return;
    if (code == psch_pkg::CMD_OPTION_LOAD) l = lo & 8'h0B;
    @(negedge i_core_clk);
    o_cmd <= {1'b1, code, l, hi};
    @(negedge i_core_clk);
    o_cmd.valid <= 1'b0;
  endtask : send
endmodule : psch_host_model

// file: verif/psch_port_setup_chk.sv
`timescale 1ns/100ps
module psch_port_setup_chk (
  input wire logic                   i_core_clk,
  input wire logic                   i_rst,
  input wire psch_pkg::psch_cmd_type i_cmd,
  input wire logic [3:0]             i_port1_pins,
  input wire logic                   i_wr_strobe_req,
  input wire logic [3:0]             o_port1_oe_n,
  input wire logic [7:0]             o_option_control,
  input wire logic                   o_serial_enable,
  input wire logic                   o_baud_tick,
  input wire logic                   o_wr_strobe,
  input wire logic [2:0]             o_rdbuf_count,
  input wire logic [15:0]            o_event_count
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // --------------------------------------------------------------
  // decoded command helpers
  // --------------------------------------------------------------
  logic pwm_cmd;  // pwm load seen
  logic pwm_ok;   // pin and duty in range
  assign pwm_cmd = i_cmd.valid && i_cmd.sub_command_code == psch_pkg::CMD_PWM_LOAD;
  assign pwm_ok  = i_cmd.low_param_byte <= psch_pkg::PWM_PIN_MAX &&
                   i_cmd.high_param_byte <= psch_pkg::PWM_DUTY_MAX;
  // acknowledge held low long enough to pass the synchroniser
  sequence ack_low_run;
    (o_option_control[3] && !i_port1_pins[2])[*3];
  endsequence
  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  a_option_load: assert property (i_cmd.valid && i_cmd.sub_command_code == 8'h28 |=>
    o_option_control == $past(i_cmd.low_param_byte)) else $error("option load lost");
  a_retired_noop: assert property (i_cmd.valid && i_cmd.sub_command_code inside
    {[8'h1E:8'h21]} |=> $stable(o_option_control)) else $error("retired code acted");
  a_serial_follows: assert property (o_serial_enable == o_option_control[1])
    else $error("serial enable differs from bit 1");
  a_tick_gated: assert property (o_baud_tick |-> o_option_control[1] ||
    $past(o_option_control[1])) else $error("baud tick while serial off");
  a_rdbuf_depth: assert property (o_rdbuf_count == 3'h7 |=> o_rdbuf_count >= 3'h6)
    else $error("full read buffer overflowed");
  a_pwm_takes_pin: assert property (pwm_cmd && pwm_ok &&
    !(o_option_control[3] && i_cmd.low_param_byte[1:0] == 2'h2) |=>
    !o_port1_oe_n[$past(i_cmd.low_param_byte[1:0])]) else $error("pwm pin not driven");
  a_pwm_bad_ignored: assert property (pwm_cmd && !pwm_ok && !o_option_control[0]
    |=> $stable(o_port1_oe_n)) else $error("bad pwm command acted");
  a_strobe_rise: assert property (i_wr_strobe_req |=> o_wr_strobe)
    else $error("write strobe did not rise");
  a_ack_holds: assert property (ack_low_run ##0 o_wr_strobe |=> o_wr_strobe)
    else $error("strobe dropped while acknowledge low");
  a_reset_values: assert property ($fell(i_rst) |-> o_option_control == 8'h00 &&
    o_rdbuf_count == 3'h0 && o_event_count == 16'h0000 && o_port1_oe_n == 4'hF)
    else $error("bad values after reset");
endmodule : psch_port_setup_chk

bind psch_port_setup psch_port_setup_chk u_psch_port_setup_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_cmd(i_cmd), .i_port1_pins(i_port1_pins),
  .i_wr_strobe_req(i_wr_strobe_req), .o_port1_oe_n(o_port1_oe_n),
  .o_option_control(o_option_control), .o_serial_enable(o_serial_enable),
  .o_baud_tick(o_baud_tick), .o_wr_strobe(o_wr_strobe), .o_rdbuf_count(o_rdbuf_count),
  .o_event_count(o_event_count));

// file: verif/psch_port_setup_tb.sv
`timescale 1ns/100ps
module psch_port_setup_tb;
  // --------------------------------------------------------------
  // signals and bench model
  // --------------------------------------------------------------
  logic                   i_core_clk = 1'b0;
  logic                   i_rst      = 1'b1;
  psch_pkg::psch_cmd_type cmd;
  logic                   legacy = 1'b0, usb_act = 1'b0, wr_req = 1'b0, pop = 1'b0;
  logic [7:0]             p0  = 8'h00;
  logic [3:0]             p1  = 4'h4;  // ack pin idles high
  logic [2:0]             sra = 3'h0;
  logic [3:0]             p1_out, oe_n, exp_oe;
  logic [7:0]             opt, rd_data, scr_data;
  logic                   ser_en, tick, strobe;
  logic [2:0]             rd_cnt;
  logic [15:0]            ev_cnt;
  int                     fails = 0, checks_done = 0, cycles = 0, ev = 0, n;
  logic [7:0]             q[$];            // expected read buffer
  logic [7:0]             scr[8];          // expected scratch pad
  logic [7:0]             rnd = 8'h36;     // lfsr state
  localparam int          LIMIT = 95000;   // serial wait dominates

  always #2.5 i_core_clk = ~i_core_clk;

  psch_host_model u_psch_host_model (.i_core_clk(i_core_clk), .i_serial_on(ser_en),
    .o_cmd(cmd));
  psch_port_setup u_psch_port_setup (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cmd(cmd),
    .i_legacy_pullup(legacy), .i_usb_activity(usb_act), .i_wr_strobe_req(wr_req),
    .i_port0_pins(p0), .i_port1_pins(p1), .i_rdbuf_pop(pop), .i_scratch_rd_addr(sra),
    .o_port1_out(p1_out), .o_port1_oe_n(oe_n), .o_option_control(opt),
    .o_serial_enable(ser_en), .o_baud_tick(tick), .o_wr_strobe(strobe),
    .o_rdbuf_data(rd_data), .o_rdbuf_count(rd_cnt), .o_scratch_data(scr_data),
    .o_event_count(ev_cnt));

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  task automatic cyc(input int k);
    repeat (k) @(negedge i_core_clk);
  endtask : cyc
  task automatic h(input logic [7:0] c, input logic [7:0] l, input logic [7:0] hb);
    u_psch_host_model.send(c, l, hb);
  endtask : h
  task automatic do_reset;
    i_rst = 1'b1;
    cyc(20);
    i_rst = 1'b0;
    q.delete();
    ev = 0;
    foreach (scr[i]) scr[i] = 8'h00;
  endtask : do_reset
  task automatic rd_scratch;
    for (int i = 0; i < 8; i++) begin
      sra = 3'(i);
      cyc(2);
      chk("scratch", scr_data, scr[i]);
    end
  endtask : rd_scratch
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish

  // hang guard
  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      tally_and_finish();
    end
  end

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    do_reset();
    chk("oe_n", oe_n, 4'hF);
    chk("rdbuf_count", rd_cnt, 3'h0);
    chk("event_count", ev_cnt, 16'h0000);
    rd_scratch();
    // option load, then retired codes must leave it alone
    h(psch_pkg::CMD_OPTION_LOAD, 8'h08, 8'h00);
    chk("option", opt, 8'h08);
    for (int c = 30; c < 34; c++) h(8'(c), 8'hFF, 8'hFF);
    chk("option", opt, 8'h08);
    // acknowledge stretches the strobe only when enabled
    p1[2] = 1'b0;
    cyc(3);  // low acknowledge must clear the synchroniser first
    wr_req = 1'b1;
    cyc(1);
    wr_req = 1'b0;
    cyc(6);
    chk("wr_strobe", strobe, 1'b1);
    p1[2] = 1'b1;
    cyc(5);
    chk("wr_strobe", strobe, 1'b0);
    h(psch_pkg::CMD_OPTION_LOAD, 8'h00, 8'h00);
    p1[2] = 1'b0;
    cyc(3);
    wr_req = 1'b1;
    cyc(1);
    wr_req = 1'b0;
    cyc(6);
    chk("wr_strobe", strobe, 1'b0);
    p1[2] = 1'b1;
    // scratch pad with random data, then an out-of-range pointer
    for (int i = 0; i < 8; i++) begin
      scr[i] = rnd;
      h(psch_pkg::CMD_SCRATCH_WR, rnd, 8'(i));
      rnd = lfsr(rnd);
    end
    h(psch_pkg::CMD_SCRATCH_WR, 8'hAA, 8'h08);
    rd_scratch();
    // read buffer: both strobe polarities, overfill, drain
    for (int pol = 0; pol < 2; pol++) begin
      legacy = pol[0];
      p1 = {2'b01, 1'b0, pol[0]};
      do_reset();
      h(psch_pkg::CMD_RDBUF_SETUP, 8'h01, 8'h00);
      for (int k = 0; k < 9; k++) begin
        p0 = rnd;
        rnd = lfsr(rnd);
        cyc(3);
        p1[0] = ~p1[0];
        cyc(3);
        p1[0] = ~p1[0];
        cyc(5);
        if (q.size() < psch_pkg::RDBUF_DEPTH) q.push_back(p0);
        chk("rdbuf_count", rd_cnt, 16'(q.size()));
      end
      while (q.size() > 0) begin
        chk("rdbuf_data", rd_data, q.pop_front());
        pop = 1'b1;
        cyc(1);
        pop = 1'b0;
        cyc(2);
      end
      chk("rdbuf_count", rd_cnt, 3'h0);
    end
    // event counter: pin 1 disable wins, both edge senses
    for (int pol = 0; pol < 2; pol++) begin
      legacy = pol[0];
      p0 = {8{pol[0]}};
      do_reset();
      h(psch_pkg::CMD_EVENT_SETUP, 8'h03, 8'h02);
      for (int k = 0; k < 5; k++) begin
        p0 = ~p0;
        cyc(4);
        if (p0[0] != pol[0]) ev++;
        chk("event_count", ev_cnt, 16'(ev));
      end
      h(psch_pkg::CMD_EVENT_SETUP, 8'h00, 8'h01);
      p0 = ~p0;
      cyc(4);
      p0 = ~p0;
      cyc(4);
      chk("event_count", ev_cnt, 16'(ev));
    end
    // pwm: refused loads first, then every pin with rising duty
    do_reset();
    h(psch_pkg::CMD_PWM_LOAD, 8'h04, 8'h32);
    h(psch_pkg::CMD_PWM_LOAD, 8'h00, 8'h65);
    cyc(2);
    chk("oe_n", oe_n, 4'hF);
    exp_oe = 4'hF;
    for (int i = 0; i < 4; i++) begin
      h(psch_pkg::CMD_PWM_LOAD, 8'(i), 8'(i * 33 + 1));
      exp_oe[i] = 1'b0;
      cyc(1);
      chk("oe_n", oe_n, exp_oe);
    end
    chk("pwm_out", p1_out, 4'hF);
    cyc(2 * psch_pkg::PWM_DIV + 100);
    chk("pwm_out", p1_out, 4'hE);
    // status indicator on pin 3
    do_reset();
    h(psch_pkg::CMD_OPTION_LOAD, 8'h01, 8'h00);
    usb_act = 1'b1;
    cyc(3);
    chk("status_pin", {oe_n[3], p1_out[3]}, 2'b00);
    usb_act = 1'b0;
    cyc(1);
    chk("status_pin", {oe_n[3], p1_out[3]}, 2'b01);
    // serial enable and baud tick spacing
    h(psch_pkg::CMD_OPTION_LOAD, 8'h02, 8'h00);
    chk("serial_enable", ser_en, 1'b1);
    n = 0;
    while (tick !== 1'b1 && n < psch_pkg::BAUD_DIV + 4) begin
      cyc(1);
      n++;
    end
    chk("baud_gap", (n > psch_pkg::BAUD_DIV - 5) && (n < psch_pkg::BAUD_DIV + 4), 1'b1);
    h(psch_pkg::CMD_OPTION_LOAD, 8'h00, 8'h00);
    chk("serial_enable", ser_en, 1'b0);
    tally_and_finish();
  end
endmodule : psch_port_setup_tb
